//--- src/tscr_defs.svh
// register map, field positions, reset values and timing counts
`ifndef TSCR_DEFS_SVH
`define TSCR_DEFS_SVH

`define TSCR_ADDR_W        8
`define TSCR_OFF_CTRL      8'h00
`define TSCR_OFF_IRQEN     8'h04
`define TSCR_OFF_FCLR      8'h08
`define TSCR_OFF_STATUS    8'h0c
`define TSCR_OFF_HYST      8'h10
`define TSCR_OFF_ASW       8'h18
`define TSCR_OFF_SAMPLE    8'h20
`define TSCR_OFF_CHANNEL   8'h28
`define TSCR_OFF_GROUP     8'h30
`define TSCR_OFF_CNT_BASE  8'h30
`define TSCR_OFF_CNT_STEP  8'h04

`define TSCR_BIT_EN        0
`define TSCR_BIT_START     1
`define TSCR_BIT_MODE      2
`define TSCR_BIT_POL       3
`define TSCR_BIT_IDLE      4
`define TSCR_MCNT_HI       7
`define TSCR_MCNT_LO       5
`define TSCR_PGDIV_HI      14
`define TSCR_PGDIV_LO      12
`define TSCR_BIT_SSDIV     15
`define TSCR_BIT_SPREAD_ENABLE      16
`define TSCR_SSERR_HI      23
`define TSCR_SSERR_LO      17
`define TSCR_LOW_HI        27
`define TSCR_LOW_LO        24
`define TSCR_HIGH_HI       31
`define TSCR_HIGH_LO       28
`define TSCR_CTRL_WMASK    32'hfffff0fd

`define TSCR_BIT_EOA       0
`define TSCR_BIT_MCE       1
`define TSCR_GDONE_LO      16

`define TSCR_RST_CTRL      32'h00000000
`define TSCR_RST_IRQEN     2'h0
`define TSCR_RST_HYST      24'hffffff
`define TSCR_RST_IO        24'h000000
`define TSCR_RST_GROUP     6'h00

`define TSCR_NUM_GROUPS    6
`define TSCR_NUM_IO        24
`define TSCR_CNT_W         14
`define TSCR_MAX_BASE_SH   8
`define TSCR_MCNT_RSVD     3'h7
`define TSCR_MCNT_TOP      3'h6
`define TSCR_SYNC_STAGES   3

`endif

//--- src/tscr_pkg.sv
// types shared by the touch sense controller modules
package tscr_pkg;
    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_SYNC = 2'b01,
        ACQ_XFER = 2'b10
    } tscr_acq_e;

    typedef enum logic [1:0] {
        PLS_IDLE   = 2'b00,
        PLS_HIGH   = 2'b01,
        PLS_SPREAD = 2'b10,
        PLS_LOW    = 2'b11
    } tscr_pulse_e;
endpackage

//--- src/tscr_pulse_if.sv
// pulse generator configuration and pulse status between the modules
interface tscr_pulse_if;
    logic       run;
    logic [2:0] pulseClkDivSel;
    logic       spreadClkDivSel;
    logic       spreadEnable;
    logic [6:0] spreadErrorSel;
    logic [3:0] pulseLowLen;
    logic [3:0] pulseHighLen;
    logic       pulseHigh;
    logic       pulseDone;

    modport gen (
        input  run, pulseClkDivSel, spreadClkDivSel, spreadEnable,
        input  spreadErrorSel, pulseLowLen, pulseHighLen,
        output pulseHigh, pulseDone
    );
    modport ctl (
        output run, pulseClkDivSel, spreadClkDivSel, spreadEnable,
        output spreadErrorSel, pulseLowLen, pulseHighLen,
        input  pulseHigh, pulseDone
    );
endinterface

//--- src/tscr_pulse_gen.sv
// charge transfer pulse generator with clock dividers and spread spectrum
`include "tscr_defs.svh"

module tscr_pulse_gen (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // configuration and pulse status
    tscr_pulse_if.gen pif
);
    logic [6:0]          divCnt;
    logic                ssPhase;
    logic                pgTick;
    logic                ssTick;
    logic [6:0]          divMask;
    logic [6:0]          lfsr;
    logic [6:0]          spreadLeft;
    logic [3:0]          phaseCnt;
    tscr_pkg::tscr_pulse_e state;

    // divide mask is 2**sel - 1, so the tick rate is clk over 2**sel
    assign divMask = 7'((8'h01 << pif.pulseClkDivSel) - 8'h01);
    assign pgTick  = ((divCnt & divMask) == divMask);
    assign ssTick  = pif.spreadClkDivSel ? ssPhase : 1'b1;

    always_ff @(posedge clk_sys) begin
        if (srst || !pif.run) begin
            divCnt  <= 7'h00;
            ssPhase <= 1'b0;
        end else begin
            divCnt  <= divCnt + 7'h01;
            ssPhase <= ~ssPhase;
        end
    end

    // free running lfsr picks the inserted spread length
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lfsr <= 7'h01;
        end else begin
            lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !pif.run) begin
            state         <= tscr_pkg::PLS_IDLE;
            phaseCnt      <= 4'h0;
            spreadLeft    <= 7'h00;
            pif.pulseHigh <= 1'b0;
            pif.pulseDone <= 1'b0;
        end else begin
            pif.pulseDone <= 1'b0;
            case (state)
                tscr_pkg::PLS_IDLE: begin
                    state         <= tscr_pkg::PLS_HIGH;
                    phaseCnt      <= 4'h0;
                    pif.pulseHigh <= 1'b1;
                end
                tscr_pkg::PLS_HIGH: begin
                    if (pgTick) begin
                        if (phaseCnt == pif.pulseHighLen) begin
                            phaseCnt <= 4'h0;
                            // masking keeps the extra length within code
                            spreadLeft <= lfsr & pif.spreadErrorSel;
                            if (pif.spreadEnable) begin
                                state <= tscr_pkg::PLS_SPREAD;
                            end else begin
                                state         <= tscr_pkg::PLS_LOW;
                                pif.pulseHigh <= 1'b0;
                            end
                        end else begin
                            phaseCnt <= phaseCnt + 4'h1;
                        end
                    end
                end
                tscr_pkg::PLS_SPREAD: begin
                    if (ssTick) begin
                        if (spreadLeft == 7'h00) begin
                            state         <= tscr_pkg::PLS_LOW;
                            pif.pulseHigh <= 1'b0;
                        end else begin
                            spreadLeft <= spreadLeft - 7'h01;
                        end
                    end
                end
                tscr_pkg::PLS_LOW: begin
                    if (pgTick) begin
                        if (phaseCnt == pif.pulseLowLen) begin
                            phaseCnt      <= 4'h0;
                            pif.pulseDone <= 1'b1;
                            pif.pulseHigh <= 1'b1;
                            state         <= tscr_pkg::PLS_HIGH;
                        end else begin
                            phaseCnt <= phaseCnt + 4'h1;
                        end
                    end
                end
                default: begin
                    state         <= tscr_pkg::PLS_IDLE;
                    pif.pulseHigh <= 1'b0;
                end
            endcase
        end
    end
endmodule

//--- src/tscr_top.sv
// touch sense controller: registers, acquisition sequencing, group counters
`include "tscr_defs.svh"

module tscr_top (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         srst,
    // register port
    input  wire logic [`TSCR_ADDR_W-1:0]      regAddr,
    input  wire logic [31:0]                  regWdata,
    input  wire logic                         regWrite,
    input  wire logic                         regRead,
    output logic      [31:0]                  regRdata,
    // pins
    input  wire logic                         syncIn,
    input  wire logic [`TSCR_NUM_GROUPS-1:0]  groupThreshold,
    output logic                              chargePulse,
    output logic                              acquiring,
    output logic                              idleIoFloat,
    // per I/O settings
    output logic      [`TSCR_NUM_IO-1:0]      ioHysteresis,
    output logic      [`TSCR_NUM_IO-1:0]      ioAnalogSwitch,
    output logic      [`TSCR_NUM_IO-1:0]      ioSampling,
    output logic      [`TSCR_NUM_IO-1:0]      ioChannel,
    // interrupt request
    output logic                              irqReq
);
    localparam int NG = `TSCR_NUM_GROUPS;
    localparam int CW = `TSCR_CNT_W;

    logic [31:0]          ctrlCfg;
    logic                 acqStart;
    logic [1:0]           irqEnable;
    logic                 acqDoneFlag;
    logic                 maxCountErrFlag;
    logic [NG-1:0]        groupEnable;
    logic [NG-1:0]        groupDoneFlag;
    logic [CW-1:0]        groupCount [NG];
    tscr_pkg::tscr_acq_e  state;

    logic [`TSCR_SYNC_STAGES-1:0] syncPipe;
    logic                 syncLevel;
    logic                 syncLevelD;
    logic [NG-1:0]        thrS1;
    logic [NG-1:0]        thrS2;
    logic [NG-1:0]        thrS3;
    logic [NG-1:0]        thrLevel;

    logic                 ctrlEnable;
    logic                 wrCtrl;
    logic                 startReq;
    logic                 syncHit;
    logic [CW-1:0]        maxLessOne;
    logic [NG-1:0]        activeGroups;
    logic [NG-1:0]        hitThreshold;
    logic [NG-1:0]        hitMax;
    logic [NG-1:0]        next_groupDone;
    logic                 finishOk;
    logic                 finishErr;
    logic                 acqDoneSet;
    logic                 maxErrSet;

    tscr_pulse_if pif ();

    // maximum pulse count for a field code, reserved code takes the top
    function automatic logic [CW-1:0] maxCount(input logic [2:0] sel);
        logic [2:0]  s;
        logic [15:0] v;
        s = (sel == `TSCR_MCNT_RSVD) ? `TSCR_MCNT_TOP : sel;
        v = (16'h0001 << (4'(s) + 4'(`TSCR_MAX_BASE_SH))) - 16'h0001;
        return v[CW-1:0];
    endfunction

    // group number 1..NG for a count register address, 0 when none
    function automatic logic [2:0] countGroup(
        input logic [`TSCR_ADDR_W-1:0] a
    );
        logic [`TSCR_ADDR_W-1:0] d;
        d = a - `TSCR_OFF_CNT_BASE;
        countGroup = 3'h0;
        if (a > `TSCR_OFF_CNT_BASE && a[1:0] == 2'b00 &&
            d <= 8'(NG) * `TSCR_OFF_CNT_STEP) begin
            countGroup = d[4:2];
        end
    endfunction

    assign ctrlEnable = ctrlCfg[`TSCR_BIT_EN];
    assign wrCtrl     = regWrite && (regAddr == `TSCR_OFF_CTRL);
    // start only counts when enabled and no acquisition is running
    assign startReq   = wrCtrl && regWdata[`TSCR_BIT_START] &&
                        regWdata[`TSCR_BIT_EN] &&
                        (state == tscr_pkg::ACQ_IDLE);

    // pulse generator configuration
    assign pif.run             = (state == tscr_pkg::ACQ_XFER);
    assign pif.pulseClkDivSel  = ctrlCfg[`TSCR_PGDIV_HI:`TSCR_PGDIV_LO];
    assign pif.spreadClkDivSel = ctrlCfg[`TSCR_BIT_SSDIV];
    assign pif.spreadEnable    = ctrlCfg[`TSCR_BIT_SPREAD_ENABLE];
    assign pif.spreadErrorSel  = ctrlCfg[`TSCR_SSERR_HI:`TSCR_SSERR_LO];
    assign pif.pulseLowLen     = ctrlCfg[`TSCR_LOW_HI:`TSCR_LOW_LO];
    assign pif.pulseHighLen    = ctrlCfg[`TSCR_HIGH_HI:`TSCR_HIGH_LO];

    tscr_pulse_gen u_pulse (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pif     (pif)
    );

    // pin inputs pass three stages; a level counts once stages 2 and 3 agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            syncPipe   <= '0;
            syncLevel  <= 1'b0;
            syncLevelD <= 1'b0;
            thrS1      <= '0;
            thrS2      <= '0;
            thrS3      <= '0;
            thrLevel   <= '0;
        end else begin
            syncPipe <= {syncPipe[`TSCR_SYNC_STAGES-2:0], syncIn};
            if (syncPipe[1] == syncPipe[2]) begin
                syncLevel <= syncPipe[2];
            end
            syncLevelD <= syncLevel;
            thrS1      <= groupThreshold;
            thrS2      <= thrS1;
            thrS3      <= thrS2;
            for (int g = 0; g < NG; g++) begin
                if (thrS2[g] == thrS3[g]) begin
                    thrLevel[g] <= thrS3[g];
                end
            end
        end
    end

    // polarity 1 accepts a high level, which covers the rising edge too
    assign syncHit = ctrlCfg[`TSCR_BIT_POL] ? syncLevel :
                     (syncLevelD && !syncLevel);

    // group evaluation at the end of each charge transfer pulse
    always_comb begin
        maxLessOne     = maxCount(ctrlCfg[`TSCR_MCNT_HI:`TSCR_MCNT_LO]) -
                         CW'(1);
        activeGroups   = groupEnable & ~groupDoneFlag;
        hitThreshold   = activeGroups & thrLevel;
        hitMax         = '0;
        for (int g = 0; g < NG; g++) begin
            hitMax[g] = activeGroups[g] && !thrLevel[g] &&
                        (groupCount[g] == maxLessOne);
        end
        next_groupDone = groupDoneFlag | hitThreshold;
        finishErr      = pif.pulseDone && (|hitMax);
        finishOk       = !finishErr &&
                         ((groupEnable == '0) ||
                          (pif.pulseDone &&
                           ((next_groupDone & groupEnable) == groupEnable)));
    end

    assign acqDoneSet = (state == tscr_pkg::ACQ_XFER) &&
                        (finishOk || finishErr);
    assign maxErrSet  = (state == tscr_pkg::ACQ_XFER) && finishErr;

    // acquisition sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state    <= tscr_pkg::ACQ_IDLE;
            acqStart <= 1'b0;
        end else if (!ctrlEnable && !startReq) begin
            state    <= tscr_pkg::ACQ_IDLE;
            acqStart <= 1'b0;
        end else begin
            case (state)
                tscr_pkg::ACQ_IDLE: begin
                    if (startReq) begin
                        acqStart <= 1'b1;
                        if (regWdata[`TSCR_BIT_MODE]) begin
                            state <= tscr_pkg::ACQ_SYNC;
                        end else begin
                            state <= tscr_pkg::ACQ_XFER;
                        end
                    end
                end
                tscr_pkg::ACQ_SYNC: begin
                    if (syncHit) begin
                        state <= tscr_pkg::ACQ_XFER;
                    end
                end
                tscr_pkg::ACQ_XFER: begin
                    if (acqDoneSet) begin
                        state    <= tscr_pkg::ACQ_IDLE;
                        acqStart <= 1'b0;
                    end
                end
                default: begin
                    state    <= tscr_pkg::ACQ_IDLE;
                    acqStart <= 1'b0;
                end
            endcase
        end
    end

    // group counters and completion flags
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            groupDoneFlag <= '0;
            for (int g = 0; g < NG; g++) begin
                groupCount[g] <= '0;
            end
        end else if (startReq) begin
            groupDoneFlag <= '0;
            for (int g = 0; g < NG; g++) begin
                groupCount[g] <= '0;
            end
        end else if (state == tscr_pkg::ACQ_XFER && pif.pulseDone) begin
            // on an error only groups at the maximum still count; done flags are not latched
            if (!finishErr) begin
                groupDoneFlag <= next_groupDone;
                for (int g = 0; g < NG; g++) begin
                    if (activeGroups[g] && !thrLevel[g]) begin
                        groupCount[g] <= groupCount[g] + CW'(1);
                    end
                end
            end else begin
                for (int g = 0; g < NG; g++) begin
                    if (hitMax[g]) begin
                        groupCount[g] <= groupCount[g] + CW'(1);
                    end
                end
            end
        end
    end

    // configuration registers; control is stored through its write mask, the rest as written
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrlCfg        <= `TSCR_RST_CTRL;
            irqEnable      <= `TSCR_RST_IRQEN;
            groupEnable    <= `TSCR_RST_GROUP;
            ioHysteresis   <= `TSCR_RST_HYST;
            ioAnalogSwitch <= `TSCR_RST_IO;
            ioSampling     <= `TSCR_RST_IO;
            ioChannel      <= `TSCR_RST_IO;
        end else if (regWrite) begin
            // mid-acquisition edits are not blocked here
            case (regAddr)
                `TSCR_OFF_CTRL:    ctrlCfg <= regWdata & `TSCR_CTRL_WMASK;
                `TSCR_OFF_IRQEN:   irqEnable <= regWdata[1:0];
                `TSCR_OFF_GROUP:   groupEnable <= regWdata[NG-1:0];
                `TSCR_OFF_HYST:    ioHysteresis <= regWdata[23:0];
                `TSCR_OFF_ASW:     ioAnalogSwitch <= regWdata[23:0];
                `TSCR_OFF_SAMPLE:  ioSampling <= regWdata[23:0];
                `TSCR_OFF_CHANNEL: ioChannel <= regWdata[23:0];
                default: begin
                end
            endcase
        end
    end

    // status flags: a hardware set in the clear cycle wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acqDoneFlag     <= 1'b0;
            maxCountErrFlag <= 1'b0;
        end else begin
            if (acqDoneSet) begin
                acqDoneFlag <= 1'b1;
            end else if (regWrite && regAddr == `TSCR_OFF_FCLR &&
                         regWdata[`TSCR_BIT_EOA]) begin
                acqDoneFlag <= 1'b0;
            end
            if (maxErrSet) begin
                maxCountErrFlag <= 1'b1;
            end else if (regWrite && regAddr == `TSCR_OFF_FCLR &&
                         regWdata[`TSCR_BIT_MCE]) begin
                maxCountErrFlag <= 1'b0;
            end
        end
    end

    // register read, data valid the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            regRdata <= 32'h00000000;
            case (regAddr)
                `TSCR_OFF_CTRL: begin
                    regRdata                   <= ctrlCfg;
                    regRdata[`TSCR_BIT_START]  <= acqStart;
                end
                `TSCR_OFF_IRQEN:   regRdata[1:0] <= irqEnable;
                `TSCR_OFF_STATUS: begin
                    regRdata[`TSCR_BIT_EOA] <= acqDoneFlag;
                    regRdata[`TSCR_BIT_MCE] <= maxCountErrFlag;
                end
                `TSCR_OFF_HYST:    regRdata[23:0] <= ioHysteresis;
                `TSCR_OFF_ASW:     regRdata[23:0] <= ioAnalogSwitch;
                `TSCR_OFF_SAMPLE:  regRdata[23:0] <= ioSampling;
                `TSCR_OFF_CHANNEL: regRdata[23:0] <= ioChannel;
                `TSCR_OFF_GROUP: begin
                    regRdata[NG-1:0] <= groupEnable;
                    regRdata[`TSCR_GDONE_LO +: NG] <= groupDoneFlag;
                end
                default: begin
                    if (countGroup(regAddr) != 3'h0) begin
                        regRdata[CW-1:0] <=
                            groupCount[countGroup(regAddr) - 3'h1];
                    end
                end
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    // pin side outputs and interrupt request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chargePulse <= 1'b0;
            acquiring   <= 1'b0;
            idleIoFloat <= 1'b0;
            irqReq      <= 1'b0;
        end else begin
            chargePulse <= pif.pulseHigh && (state == tscr_pkg::ACQ_XFER);
            acquiring   <= (state != tscr_pkg::ACQ_IDLE);
            idleIoFloat <= ctrlEnable && ctrlCfg[`TSCR_BIT_IDLE];
            irqReq      <= (acqDoneFlag && irqEnable[0]) ||
                           (maxCountErrFlag && irqEnable[1]);
        end
    end
endmodule

//--- testbench/tscr_assertions.sv
// port-level assertions for the touch sense controller
module tscr_assertions (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        chargePulse,
    input wire logic        acquiring,
    input wire logic        idleIoFloat,
    input wire logic        irqReq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctl;
    logic [4:0]  hiCnt;
    wire         wCtl = regWrite && regAddr == 8'h00;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // shadow of control, so pulse widths can be judged
    always_ff @(posedge clk_sys) begin
        if (srst)
            ctl <= 32'h0;
        else if (wCtl)
            ctl <= regWdata;
    end
    always_ff @(posedge clk_sys) begin
        hiCnt <= chargePulse ? hiCnt + 5'h1 : 5'h0;
    end
    property p_rd_idle; !$past(regRead) |-> regRdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_unmap; regRead && regAddr == 8'h14 |=> regRdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_fclr; regRead && regAddr == 8'h08 |=> regRdata == 32'h0;
    endproperty
    a_fclr: assert property (p_fclr) else $error("clear reg read");
    // acquiring follows the sequencer state one flop later
    property p_start; wCtl && regWdata[1:0] == 2'h3 && !acquiring
        |=> ##1 acquiring;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_dis;
        wCtl && !regWdata[0]
            |=> ##2 !acquiring && !chargePulse && !idleIoFloat;
    endproperty
    a_dis: assert property (p_dis) else $error("disable ignored");
    property p_idle; wCtl && regWdata[0]
        |=> ##1 idleIoFloat == $past(regWdata[4], 2);
    endproperty
    a_idle: assert property (p_idle) else $error("idle config");
    property p_high; $fell(chargePulse) && acquiring && ctl[16:12] == 5'h0
        |-> hiCnt == {1'h0, ctl[31:28]} + 5'h1; endproperty
    a_high: assert property (p_high) else $error("high phase");
    property p_irq; regWrite && regAddr == 8'h04 && regWdata[1:0] == 2'h0
        |=> ##1 !irqReq; endproperty
    a_irq: assert property (p_irq) else $error("irq not gated");
    c_end: cover property ($fell(acquiring));
    c_irq: cover property ($rose(irqReq));
    c_sync: cover property ($rose(chargePulse) && ctl[2]);
endmodule

bind tscr_top tscr_assertions chk_u (.*);

//--- testbench/tscr_electrode_model.sv
// electrode and sampling capacitor stand-in for all six groups
module tscr_electrode_model #(parameter int FILL = 5) (
    input  wire logic       clk_sys,
    input  wire logic       chargePulse,
    input  wire logic       acquiring,
    input  wire logic       stuck,
    output logic      [5:0] groupThreshold = 6'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int   n = 0;
    logic last = 1'h0;
    // capacitor drains between acquisitions; stuck holds all six groups below threshold
    always @(posedge clk_sys) begin
        last <= chargePulse;
        n <= !acquiring ? 0 : n + int'(last && !chargePulse);
        groupThreshold <= {6{acquiring && !stuck && n >= FILL}};
    end
endmodule

//--- testbench/tb_touch_sense_control_regs.sv
// self-checking bench for the touch sense controller
module tb_touch_sense_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'h0;
    logic        srst = 1'h1;
    logic        regWrite = 1'h0;
    logic        regRead = 1'h0;
    logic        syncIn = 1'h0;
    logic        stuck = 1'h0;
    logic [7:0]  regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic [5:0]  thr;
    logic        cp, acq, idleF, irq;
    int          num_errors = 0;
    int          checks = 0;
    tscr_top dut_u (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .syncIn(syncIn), .groupThreshold(thr),
        .chargePulse(cp), .acquiring(acq), .idleIoFloat(idleF),
        .ioHysteresis(), .ioAnalogSwitch(), .ioSampling(), .ioChannel(),
        .irqReq(irq));
    tscr_electrode_model elec_u (.clk_sys(clk_sys), .chargePulse(cp),
        .acquiring(acq), .stuck(stuck), .groupThreshold(thr));
    initial forever #5 clk_sys = ~clk_sys;
    task automatic close_out;
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk_sys);
        regWrite <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk_sys);
        regRead <= 1'h0;
        #1;
        cmp(regRdata, e);
    endtask
    // bounded wait for the end of acquisition; config is left alone meanwhile
    task automatic wait_idle(input int lim);
        repeat (lim) begin
            @(posedge clk_sys);
            #1;
            if (acq === 1'h0)
                return;
        end
        num_errors++;
        close_out();
    endtask
    task automatic t_reset;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h00ffffff);
        rd(8'h18, 32'h0);
    endtask
    task automatic t_regs;
        wr(8'h00, 32'h5a5afff4);
        rd(8'h00, 32'h5a5af0f4);
        cmp({31'h0, idleF}, 32'h0);
        wr(8'h0c, 32'h3);
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h0);
    endtask
    task automatic t_acq;
        wr(8'h30, 32'h3f);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h10000013);
        // acquiring lags the start write by two flops
        @(posedge clk_sys);
        #1;
        cmp({31'h0, acq}, 32'h1);
        wait_idle(500);
        rd(8'h0c, 32'h1);
        rd(8'h00, 32'h10000011);
        rd(8'h30, 32'h003f003f);
        cmp({30'h0, irq, idleF}, 32'h3);
        wr(8'h08, 32'h2);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h1);
        wr(8'h08, 32'h1);
        rd(8'h0c, 32'h0);
        cmp({31'h0, irq}, 32'h0);
    endtask
    task automatic t_max;
        stuck <= 1'h1;
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h3);
        wait_idle(2000);
        rd(8'h0c, 32'h3);
        rd(8'h30, 32'h3f);
        rd(8'h34, 32'hff);
        cmp({31'h0, irq}, 32'h1);
        wr(8'h04, 32'h0);
        rd(8'h0c, 32'h3);
        cmp({31'h0, irq}, 32'h0);
        wr(8'h08, 32'h3);
        stuck <= 1'h0;
    endtask
    task automatic t_sync(input logic pol);
        syncIn <= !pol;
        repeat (8) @(posedge clk_sys);
        // falling edge run also uses divider, spread and a longer low phase
        wr(8'h00, {pol ? 20'h00000 : 20'h01099, 8'h00, pol, 3'h7});
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            cmp({31'h0, cp}, 32'h0);
        end
        syncIn <= pol;
        wait_idle(500);
        rd(8'h0c, 32'h1);
        wr(8'h08, 32'h3);
    endtask
    task automatic t_abort;
        stuck <= 1'h1;
        wr(8'h00, 32'h3);
        repeat (20) @(posedge clk_sys);
        wr(8'h00, 32'h0);
        rd(8'h0c, 32'h0);
        stuck <= 1'h0;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_regs();
        t_acq();
        t_max();
        t_sync(1'h1);
        t_sync(1'h0);
        t_abort();
        close_out();
    end
endmodule
